// ### hw/jfp_pkg.sv
package jfp_pkg;
   // instruction register codes
   localparam int IR_W = 4;
   localparam logic [IR_W-1:0] PROG_UNLOCK_INSTR = 4'h4;
   localparam logic [IR_W-1:0] PROG_COMMAND_INSTR = 4'h5;
   localparam logic [IR_W-1:0] PAGE_LOAD_INSTR = 4'h6;
   localparam logic [IR_W-1:0] PAGE_READ_INSTR = 4'h7;
   localparam logic [IR_W-1:0] PART_RESET_INSTR = 4'hc;

   // data register geometry
   localparam int CMD_W = 15;
   localparam int BYTE_W = 8;
   localparam int WORD_W = 16;
   localparam int UNLOCK_W = 16;
   localparam logic [UNLOCK_W-1:0] UNLOCK_KEY = 16'ha370;
   localparam logic [CMD_W-1:0] CMD_RESET = 15'h0000;
   localparam logic [UNLOCK_W-1:0] UNLOCK_RESET = 16'h0000;

   // reset time-out after the reset bit is released
   localparam int CLK_MHZ = 200;
   localparam int TOUT_SHORT_US = 16;
   localparam int TOUT_LONG_US = 4100;
   localparam int TOUT_SHORT_CYC = TOUT_SHORT_US * CLK_MHZ;
   localparam int TOUT_LONG_CYC = TOUT_LONG_US * CLK_MHZ;
   localparam int TOUT_W = 20;

   // test-port state strobes from the tap controller, tck domain
   typedef struct packed {
      logic capture_dr;
      logic shift_dr;
      logic update_dr;
      logic update_ir;
      logic [IR_W-1:0] ir;
   } jfp_tap_s;

   // one page-load byte handed to the system clock side
   typedef struct packed {
      logic [BYTE_W-1:0] data;
      logic hi;
      logic first;
   } jfp_pl_req_s;
endpackage : jfp_pkg

// ### hw/jfp_sync.sv
`timescale 1ns/10ps
module jfp_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_r;

   // meta_r is read by q only
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= '0;
         q <= '0;
      end else begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule : jfp_sync

// ### hw/jfp_rst_tout.sv
`timescale 1ns/10ps
module jfp_rst_tout import jfp_pkg::*; #(
   parameter int SHORT_CYC = TOUT_SHORT_CYC,
   parameter int LONG_CYC = TOUT_LONG_CYC
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic hold,
   input wire logic long_sel,
   output logic part_rst_n
);
   logic [TOUT_W-1:0] cnt_r;
   logic [TOUT_W-1:0] cnt_nxt;
   logic [TOUT_W-1:0] limit;

   assign limit = long_sel ? TOUT_W'(LONG_CYC) : TOUT_W'(SHORT_CYC);
   assign cnt_nxt = hold ? limit : (cnt_r != '0) ? cnt_r - TOUT_W'(1) : cnt_r;

   // after power-up the count is zero, so the part leaves reset one clock after rst_n rises
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= '0;
         part_rst_n <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         part_rst_n <= !(hold || cnt_r != '0);
      end
   end
endmodule : jfp_rst_tout

// ### hw/jfp_prog_regs.sv
// How it works
// - code 0x6 selects the flash byte register
// - fifteen-bit command register, low byte shared
// - byte register shifts each tck in shift
// - update copies byte; buffer write within 11
// - page-load updates alternate low then high
// - pc pre-increments before low bytes, not first
// - code 0x7 selects byte register for reading
// - byte register is command register low bits
// - capture loads flash byte, low first, alternating
// - pc post-increments after every high byte read
// - reset bit high holds the part reset
// - reset held for time-out after release
// - reset bit acts without update latch
// - programming enabled only on exact key match
// - power-on reset clears the enable register
`timescale 1ns/10ps
module jfp_prog_regs import jfp_pkg::*; #(
   parameter int ADDR_W = 16,
   parameter int TOUT_SHORT = TOUT_SHORT_CYC,
   parameter int TOUT_LONG = TOUT_LONG_CYC
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic tck,
   input wire jfp_tap_s tap,
   input wire logic tdi,
   output logic tdo,
   input wire logic [CMD_W-1:0] cmd_result,
   output logic [CMD_W-1:0] cmd_word,
   output logic cmd_strobe,
   input wire logic pc_load,
   input wire logic [ADDR_W-1:0] pc_load_addr,
   input wire logic [WORD_W-1:0] flash_rdata,
   output logic [ADDR_W-1:0] flash_addr,
   output logic pb_we,
   output logic [ADDR_W-1:0] pb_addr,
   output logic pb_hi,
   output logic [BYTE_W-1:0] pb_data,
   input wire logic tout_long,
   output logic part_rst_n,
   output logic prog_enabled
);
   // ---------------- tck domain ----------------
   logic [CMD_W-1:0] cmd_sr_r;
   logic [CMD_W-1:0] cmd_sr_nxt;
   logic [UNLOCK_W-1:0] unlock_sr_r;
   logic [UNLOCK_W-1:0] unlock_r;
   logic rst_bit_r;
   logic pl_hi_r;
   logic pl_first_r;
   logic pl_tgl_r;
   jfp_pl_req_s pl_req_r;
   logic rd_hi_r;
   logic rd_tgl_r;
   logic [WORD_W-1:0] rd_word_r;

   wire sel_load = tap.ir == PAGE_LOAD_INSTR;
   wire sel_read = tap.ir == PAGE_READ_INSTR;
   wire sel_cmd = tap.ir == PROG_COMMAND_INSTR;
   wire sel_unlock = tap.ir == PROG_UNLOCK_INSTR;
   wire sel_rst = tap.ir == PART_RESET_INSTR;
   wire sel_byte = sel_load || sel_read;
   wire prog_en_t = unlock_r == UNLOCK_KEY;
   wire pl_fire = tap.update_dr && sel_load && prog_en_t;
   wire rd_fire = tap.capture_dr && sel_read && prog_en_t;
   wire [BYTE_W-1:0] rd_byte = rd_hi_r ? rd_word_r[WORD_W-1:BYTE_W] : rd_word_r[BYTE_W-1:0];
   wire [BYTE_W-1:0] byte_shift = {tdi, cmd_sr_r[BYTE_W-1:1]};
   wire tdo_sel = sel_rst ? rst_bit_r : sel_unlock ? unlock_sr_r[0] : cmd_sr_r[0];

   // byte register is the low end of the command chain, no storage of its own
   always_comb begin
      cmd_sr_nxt = cmd_sr_r;
      if (tap.capture_dr && sel_cmd) begin
         cmd_sr_nxt = cmd_result;
      end else if (rd_fire) begin
         cmd_sr_nxt[BYTE_W-1:0] = rd_byte;
      end else if (tap.shift_dr && sel_cmd) begin
         cmd_sr_nxt = {tdi, cmd_sr_r[CMD_W-1:1]};
      end else if (tap.shift_dr && sel_byte) begin
         cmd_sr_nxt[BYTE_W-1:0] = byte_shift;
      end
   end

   always_ff @(posedge tck or negedge rst_n) begin
      if (!rst_n) begin
         cmd_sr_r <= CMD_RESET;
         cmd_word <= CMD_RESET;
         cmd_strobe <= 1'b0;
      end else begin
         cmd_sr_r <= cmd_sr_nxt;
         cmd_strobe <= tap.update_dr && sel_cmd;
         if (tap.update_dr && sel_cmd) begin
            cmd_word <= cmd_sr_r;
         end
      end
   end

   // reset bit drives the part straight from the shift stage
   always_ff @(posedge tck or negedge rst_n) begin
      if (!rst_n) begin
         rst_bit_r <= 1'b0;
      end else if (tap.shift_dr && sel_rst) begin
         rst_bit_r <= tdi;
      end
   end

   // compare on the updated copy so a passing shift pattern cannot unlock
   always_ff @(posedge tck or negedge rst_n) begin
      if (!rst_n) begin
         unlock_sr_r <= UNLOCK_RESET;
         unlock_r <= UNLOCK_RESET;
      end else begin
         if (tap.shift_dr && sel_unlock) begin
            unlock_sr_r <= {tdi, unlock_sr_r[UNLOCK_W-1:1]};
         end
         if (tap.update_dr && sel_unlock) begin
            unlock_r <= unlock_sr_r;
         end
      end
   end

   always_ff @(posedge tck or negedge rst_n) begin
      if (!rst_n) begin
         pl_hi_r <= 1'b0;
         pl_first_r <= 1'b1;
         pl_tgl_r <= 1'b0;
         pl_req_r <= '0;
      end else if (tap.update_ir) begin
         pl_hi_r <= 1'b0;
         pl_first_r <= 1'b1;
      end else if (pl_fire) begin
         pl_req_r <= '{data: cmd_sr_r[BYTE_W-1:0], hi: pl_hi_r, first: pl_first_r};
         pl_hi_r <= !pl_hi_r;
         pl_first_r <= 1'b0;
         pl_tgl_r <= !pl_tgl_r;
      end
   end

   // update under page-read is deliberately ignored
   always_ff @(posedge tck or negedge rst_n) begin
      if (!rst_n) begin
         rd_hi_r <= 1'b0;
         rd_tgl_r <= 1'b0;
      end else if (tap.update_ir) begin
         rd_hi_r <= 1'b0;
      end else if (rd_fire) begin
         rd_hi_r <= !rd_hi_r;
         if (rd_hi_r) begin
            rd_tgl_r <= !rd_tgl_r;
         end
      end
   end

   always_ff @(negedge tck or negedge rst_n) begin
      if (!rst_n) begin
         tdo <= 1'b0;
      end else begin
         tdo <= tdo_sel;
      end
   end

   // ---------------- clk domain ----------------
   logic [4:0] sync_q;
   logic pl_seen_r;
   logic rd_seen_r;
   logic [ADDR_W-1:0] pc_r;
   logic [ADDR_W-1:0] pc_nxt;

   jfp_sync #(.W(5)) u_sync (
      .clk(clk),
      .rst_n(rst_n),
      .d({tout_long, prog_en_t, rst_bit_r, rd_tgl_r, pl_tgl_r}),
      .q(sync_q)
   );

   wire pl_evt = sync_q[0] ^ pl_seen_r;
   wire rd_evt = sync_q[1] ^ rd_seen_r;
   wire rst_hold = sync_q[2];
   wire tout_long_s = sync_q[4];
   // pl_req_r and rd_word_r are quasi-static: each only moves a full toggle round trip apart
   wire [ADDR_W-1:0] pl_addr = (!pl_req_r.hi && !pl_req_r.first) ? pc_r + ADDR_W'(1) : pc_r;

   assign pc_nxt = pc_load ? pc_load_addr : pl_evt ? pl_addr : rd_evt ? pc_r + ADDR_W'(1) : pc_r;
   assign flash_addr = pc_r;
   assign prog_enabled = sync_q[3];

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pl_seen_r <= 1'b0;
         rd_seen_r <= 1'b0;
         pc_r <= '0;
         rd_word_r <= '0;
         pb_we <= 1'b0;
         pb_addr <= '0;
         pb_hi <= 1'b0;
         pb_data <= '0;
      end else begin
         pl_seen_r <= sync_q[0];
         rd_seen_r <= sync_q[1];
         pc_r <= pc_nxt;
         rd_word_r <= flash_rdata;
         pb_we <= pl_evt;
         if (pl_evt) begin
            pb_addr <= pl_addr;
            pb_hi <= pl_req_r.hi;
            pb_data <= pl_req_r.data;
         end
      end
   end

   jfp_rst_tout #(.SHORT_CYC(TOUT_SHORT), .LONG_CYC(TOUT_LONG)) u_tout (
      .clk(clk),
      .rst_n(rst_n),
      .hold(rst_hold),
      .long_sel(tout_long_s),
      .part_rst_n(part_rst_n)
   );

   // ---------------- checks ----------------
   property p_cmd_shift;
      @(posedge tck) disable iff (!rst_n)
      tap.shift_dr && sel_cmd && !tap.capture_dr |=> cmd_sr_r[CMD_W-1] == $past(tdi);
   endproperty
   a_cmd_shift: assert property (p_cmd_shift) else $error("command chain did not take tdi");

   property p_byte_shift;
      @(posedge tck) disable iff (!rst_n)
      tap.shift_dr && sel_byte && !tap.capture_dr
         |=> cmd_sr_r[BYTE_W-1] == $past(tdi) && cmd_sr_r[CMD_W-1:BYTE_W] == $past(cmd_sr_r[CMD_W-1:BYTE_W]);
   endproperty
   a_byte_shift: assert property (p_byte_shift) else $error("byte register shift wrong");

   // own record of a page-load byte since the last instruction load, kept apart from the alternation logic
   logic chk_pl_seen_r;
   always_ff @(posedge tck or negedge rst_n) begin
      if (!rst_n) begin
         chk_pl_seen_r <= 1'b0;
      end else if (tap.update_ir) begin
         chk_pl_seen_r <= 1'b0;
      end else if (pl_fire) begin
         chk_pl_seen_r <= 1'b1;
      end
   end

   property p_load_first_low;
      @(posedge tck) disable iff (!rst_n)
      pl_fire && !tap.update_ir && !chk_pl_seen_r |=> !pl_req_r.hi && pl_req_r.first;
   endproperty
   a_load_first_low: assert property (p_load_first_low) else $error("first page-load byte not low");

   property p_load_alternate;
      @(posedge tck) disable iff (!rst_n)
      pl_fire && !tap.update_ir |=> pl_hi_r != $past(pl_hi_r) && pl_req_r.hi == $past(pl_hi_r);
   endproperty
   a_load_alternate: assert property (p_load_alternate) else $error("page-load byte did not alternate");

   property p_read_capture;
      @(posedge tck) disable iff (!rst_n)
      rd_fire && !tap.update_ir |=> cmd_sr_r[BYTE_W-1:0] == $past(rd_byte) && rd_hi_r != $past(rd_hi_r);
   endproperty
   a_read_capture: assert property (p_read_capture) else $error("page-read capture wrong");

   property p_read_update_idle;
      @(posedge tck) disable iff (!rst_n)
      tap.update_dr && sel_read && !tap.update_ir |=> $stable(rd_hi_r) && $stable(rd_tgl_r) && $stable(pl_tgl_r);
   endproperty
   a_read_update_idle: assert property (p_read_update_idle) else $error("page-read update had an effect");

   property p_unlock;
      @(posedge tck) disable iff (!rst_n)
      tap.update_dr && sel_unlock |=> prog_en_t == ($past(unlock_sr_r) == UNLOCK_KEY);
   endproperty
   a_unlock: assert property (p_unlock) else $error("unlock does not follow key match");

   property p_pb_write;
      @(posedge clk) disable iff (!rst_n)
      pl_evt && !pc_load |=> pb_we && pb_addr == pc_r && pb_addr == $past(pl_addr);
   endproperty
   a_pb_write: assert property (p_pb_write) else $error("page buffer write missing or misplaced");

   property p_preinc;
      @(posedge clk) disable iff (!rst_n)
      pl_evt && !pc_load && !pl_req_r.hi && !pl_req_r.first |=> pc_r == $past(pc_r) + ADDR_W'(1);
   endproperty
   a_preinc: assert property (p_preinc) else $error("low byte did not pre-increment");

   property p_postinc;
      @(posedge clk) disable iff (!rst_n)
      rd_evt && !pc_load && !pl_evt |=> pc_r == $past(pc_r) + ADDR_W'(1);
   endproperty
   a_postinc: assert property (p_postinc) else $error("high byte read did not post-increment");

   property p_rst_hold;
      @(posedge clk) disable iff (!rst_n)
      rst_hold |=> !part_rst_n;
   endproperty
   a_rst_hold: assert property (p_rst_hold) else $error("part left reset while bit set");

   property p_tout;
      @(posedge clk) disable iff (!rst_n)
      $fell(rst_hold) |-> !part_rst_n ##1 !part_rst_n ##1 !part_rst_n;
   endproperty
   a_tout: assert property (p_tout) else $error("reset released without time-out");

   c_page_load: cover property (@(posedge clk) disable iff (!rst_n) pb_we && pb_hi);
   c_page_read: cover property (@(posedge clk) disable iff (!rst_n) rd_evt);
   c_unlocked: cover property (@(posedge tck) disable iff (!rst_n) $rose(prog_en_t));
   c_part_reset: cover property (@(posedge clk) disable iff (!rst_n) $rose(part_rst_n));
endmodule : jfp_prog_regs

// ### verif/jfp_host.sv
`timescale 1ns/10ps
module jfp_host import jfp_pkg::*; (
   output logic tck,
   output jfp_tap_s tap,
   output logic tdi,
   input wire logic tdo
);
   // tck only runs inside the tasks, so it stands still between frames
   initial begin
      tck = 1'b0;
      tap = '0;
      tdi = 1'b0;
   end

   task automatic cyc(input logic cap, input logic sh, input logic upd, input logic uir, input logic bi,
                      output logic bo);
      tap.capture_dr = cap;
      tap.shift_dr = sh;
      tap.update_dr = upd;
      tap.update_ir = uir;
      // an unused data line keeps toggling so a stale bit is never mistaken for data
      tdi = sh ? bi : ~tdi;
      #61.5 tck = 1'b0;
      #62.5 bo = tdo;
      tck = 1'b1;
      // next inputs follow one step after the rising edge
      #1;
   endtask : cyc

   task automatic ir(input logic [IR_W-1:0] code);
      logic b;
      tap.ir = code;
      cyc(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, b);
   endtask : ir

   task automatic idle(input int n);
      logic b;
      repeat (n) cyc(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, b);
   endtask : idle

   task automatic dr(input logic cap, input logic upd, input int n, input logic [15:0] din,
                     output logic [15:0] dout);
      logic b;
      dout = '0;
      if (cap) cyc(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, b);
      for (int i = 0; i < n; i++) begin
         cyc(1'b0, 1'b1, 1'b0, 1'b0, din[i], b);
         dout[i] = b;
      end
      if (upd) cyc(1'b0, 1'b0, 1'b1, 1'b0, 1'b0, b);
   endtask : dr
endmodule : jfp_host

// ### verif/jfp_prog_regs_bench.sv
`timescale 1ns/10ps
module jfp_prog_regs_bench;
   import jfp_pkg::*;
   localparam int TS = 4;
   localparam int TL = 8;
   logic clk, rst_n, tck, tdi, tdo, cmd_strobe, pc_load, pb_we, pb_hi, tout_long, part_rst_n, prog_enabled;
   jfp_tap_s tap;
   logic [CMD_W-1:0] cmd_result, cmd_word;
   logic [15:0] pc_load_addr, flash_addr, pb_addr, d;
   logic [WORD_W-1:0] flash_rdata;
   logic [BYTE_W-1:0] pb_data;
   logic [24:0] pbq[$];
   int num_errors = 0;
   int samples_checked = 0;
   int strobes = 0;

   jfp_prog_regs #(.ADDR_W(16), .TOUT_SHORT(TS), .TOUT_LONG(TL)) u_dut (.clk(clk), .rst_n(rst_n), .tck(tck),
      .tap(tap), .tdi(tdi), .tdo(tdo), .cmd_result(cmd_result), .cmd_word(cmd_word), .cmd_strobe(cmd_strobe),
      .pc_load(pc_load), .pc_load_addr(pc_load_addr), .flash_rdata(flash_rdata), .flash_addr(flash_addr),
      .pb_we(pb_we), .pb_addr(pb_addr), .pb_hi(pb_hi), .pb_data(pb_data), .tout_long(tout_long),
      .part_rst_n(part_rst_n), .prog_enabled(prog_enabled));
   jfp_host u_host (.tck(tck), .tap(tap), .tdi(tdi), .tdo(tdo));

   // flash word is a pattern of its own address
   assign flash_rdata = {~flash_addr[7:0], flash_addr[7:0]};
   always #2.5 clk = ~clk;
   always @(negedge clk) if (pb_we === 1'b1) pbq.push_back({pb_addr, pb_hi, pb_data});
   always @(negedge tck) if (cmd_strobe === 1'b1) strobes++;

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic wrap_up();
      $display("checks %0d, mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : wrap_up

   task automatic load_pc(input logic [15:0] a);
      @(posedge clk) #1 pc_load = 1'b1;
      pc_load_addr = a;
      @(posedge clk) #1 pc_load = 1'b0;
   endtask : load_pc

   task automatic t_unlock(input logic [15:0] key, input logic exp);
      u_host.ir(PROG_UNLOCK_INSTR);
      u_host.dr(1'b0, 1'b1, 16, key, d);
      u_host.idle(2);
      check(prog_enabled, exp);
      $display("test unlock %h done", key);
   endtask : t_unlock

   task automatic t_load();
      u_host.ir(PAGE_LOAD_INSTR);
      for (int i = 0; i < 4; i++) begin
         u_host.dr(1'b0, 1'b1, 8, 16'(8'ha1 + 8'(i * 17)), d);
         u_host.idle(10);
         check(pbq.size(), i + 1);
         check(pbq[i], {16'h5aff + 16'(i / 2), 1'(i % 2), 8'ha1 + 8'(i * 17)});
      end
      $display("test page load done");
   endtask : t_load

   task automatic t_read();
      logic [15:0] a;
      logic [7:0] e;
      u_host.ir(PAGE_READ_INSTR);
      for (int i = 0; i < 4; i++) begin
         a = 16'ha5fe + 16'(i / 2);
         e = (i % 2) ? ~a[7:0] : a[7:0];
         u_host.dr(1'b1, 1'b1, 8, 16'h0000, d);
         check(d[7:0], e);
      end
      u_host.idle(3);
      check(flash_addr, 16'ha600);
      check(pbq.size(), 4);
      $display("test page read done");
   endtask : t_read

   task automatic t_cmd(input logic [CMD_W-1:0] res, input logic [CMD_W-1:0] cmd);
      int s0;
      s0 = strobes;
      cmd_result = res;
      u_host.ir(PROG_COMMAND_INSTR);
      u_host.dr(1'b1, 1'b1, 15, 16'(cmd), d);
      u_host.idle(1);
      check(d[14:0], res);
      check(cmd_word, cmd);
      check(strobes - s0, 1);
      // no capture: the byte path shows what the command chain still holds
      u_host.ir(PAGE_LOAD_INSTR);
      u_host.dr(1'b0, 1'b0, 8, 16'h0000, d);
      check(d[7:0], cmd[7:0]);
      $display("test command %h done", cmd);
   endtask : t_cmd

   task automatic t_release(input logic lg);
      int n;
      @(posedge clk) #1 tout_long = lg;
      u_host.ir(PART_RESET_INSTR);
      u_host.dr(1'b0, 1'b0, 1, 16'h0001, d);
      u_host.idle(1);
      check(part_rst_n, 1'b0);
      u_host.dr(1'b0, 1'b0, 1, 16'h0000, d);
      n = 0;
      // sampled a step after each edge; sync and count latency adds a few cycles to the time-out
      while (part_rst_n !== 1'b1 && n < 400) begin
         @(posedge clk) #1;
         n++;
      end
      check(n >= (lg ? TL : TS) && n <= (lg ? TL : TS) + 5, 1);
      $display("test reset release %0d done", lg);
   endtask : t_release

   initial begin
      clk = 1'b0;
      rst_n = 1'b0;
      cmd_result = '0;
      pc_load = 1'b0;
      pc_load_addr = '0;
      tout_long = 1'b0;
      repeat (20) @(posedge clk);
      #1 rst_n = 1'b1;
      repeat (3) @(posedge clk);
      check(prog_enabled, 1'b0);
      check(part_rst_n, 1'b1);
      // part is held in reset before programming starts
      u_host.ir(PART_RESET_INSTR);
      u_host.dr(1'b0, 1'b0, 1, 16'h0001, d);
      u_host.idle(1);
      check(part_rst_n, 1'b0);
      u_host.ir(PAGE_LOAD_INSTR);
      u_host.dr(1'b0, 1'b1, 8, 16'h0055, d);
      u_host.idle(10);
      check(pbq.size(), 0);
      t_unlock(16'ha371, 1'b0);
      t_unlock(16'h2370, 1'b0);
      t_unlock(16'ha370, 1'b1);
      load_pc(16'h5aff);
      t_load();
      load_pc(16'ha5fe);
      t_read();
      t_cmd(15'h4d2b, 15'h2a55);
      t_cmd(15'h32d4, 15'h55aa);
      // leaving programming clears the enable register
      t_unlock(16'h0000, 1'b0);
      t_release(1'b0);
      t_release(1'b1);
      wrap_up();
   end

   initial begin
      #400us;
      num_errors++;
      wrap_up();
   end
endmodule : jfp_prog_regs_bench
